// *** tsm_pkg.sv ***
// Package of constants and carrier types for the timer and serial pin mux.
package tsm_pkg;

  // ==========================================================================
  // Remap option bit positions.
  localparam int unsigned REMAP_CH_ONE_BIT   = 4;  // Channel 1 alternate pad select.
  localparam int unsigned REMAP_CH_TWO_BIT   = 5;  // Channel 2 alternate pad select.
  localparam int unsigned REMAP_CH_THREE_BIT = 6;  // Channel 3 alternate pad select.
  localparam int unsigned REMAP_CH_FOUR_BIT  = 7;  // Channel 4 alternate pad select.
  localparam int unsigned REMAP_W            = 8;  // Width of the remap option value.

  // ==========================================================================
  // Controller configuration bit positions.
  localparam int unsigned UART_FLOW_BIT  = 5;  // Flow control enable in UART config.
  localparam int unsigned SPI_MASTER_BIT = 4;  // Master select in SPI config.
  localparam int unsigned CFG_W          = 8;  // Width of each controller config value.

  // ==========================================================================
  // Pad configuration field layout.
  localparam int unsigned PAD_FIELD_W  = 4;   // Bits per pad configuration field.
  localparam int unsigned PORT_CFG_W   = 16;  // Width of a port config register half.
  localparam int unsigned PA0_FIELD_LO = 0;   // Port A pad 0 field low bit.
  localparam int unsigned PA1_FIELD_LO = 4;   // Port A pad 1 field low bit.
  localparam int unsigned PA2_FIELD_LO = 8;   // Port A pad 2 field low bit.
  localparam int unsigned PA3_FIELD_LO = 12;  // Port A pad 3 field low bit.
  localparam int unsigned PB4_FIELD_LO = 0;   // Port B pad 4 field low bit.
  localparam int unsigned NUM_PADS     = 5;   // Pads handled by this mux.
  localparam int unsigned NUM_CH       = 4;   // Timer channels handled.

  // Pad function encodings inside a 4-bit field.
  localparam logic [3:0] PAD_CFG_ALT_OUT    = 4'h9;  // Alternate push-pull output.
  localparam logic [3:0] PAD_CFG_ALT_OUT_OD = 4'hD;  // Alternate open-drain output.
  localparam logic [3:0] PAD_CFG_RESET      = 4'h4;  // Reset value: plain input.

  // Pad indices in the pad vectors.
  localparam int unsigned PAD_A0 = 0;  // Index of port_a_0.
  localparam int unsigned PAD_A1 = 1;  // Index of port_a_1.
  localparam int unsigned PAD_A2 = 2;  // Index of port_a_2.
  localparam int unsigned PAD_A3 = 3;  // Index of port_a_3.
  localparam int unsigned PAD_B4 = 4;  // Index of port_b_4.

  // ==========================================================================
  // Serial controller mode encodings.
  typedef enum logic [1:0] {
    TSM_MODE_OFF  = 2'h0,  // Controller disabled.
    TSM_MODE_UART = 2'h1,  // Asynchronous serial.
    TSM_MODE_SPI  = 2'h2,  // SPI master or slave.
    TSM_MODE_TWO  = 2'h3   // Two-wire bus.
  } tsm_mode_t;

  // Per-pad drive state bundle.
  typedef struct packed {
    logic out;  // Level driven onto the pad.
    logic oe;   // High while the pad is driven.
  } tsm_pad_drv_t;

  // Timer channel signals, one bit per channel, channel 1 at bit 0.
  typedef struct packed {
    logic [3:0] out;     // Compare outputs from the timer.
    logic [3:0] out_en;  // Output enables from the capture/compare enable register.
  } tsm_timer_t;

endpackage : tsm_pkg

// *** tsm_pin_mux.sv ***
// Pin multiplexer for four timer channels, two serial controllers and trace clock.
// Summary of operation
// - Channel four: remap bit 7 picks pad b4/a2.
// - Channel one on pad a0 unless bit 4.
// - Channel three on pad a1 unless bit 6.
// - Channel two on pad a3 unless bit 5.
// - Timer drives pad if enabled and alternate selected.
// - Each pad has its own 4-bit field.
// - Request-to-send needs UART mode plus flow enable.
// - SPI master two drives data a0, clock a2.
// - SPI slave two inputs a0, a2, a3.
// - Pad a1: slave data out, master data in.
// - Two-wire data a1, clock a2, open drain.
// - SPI slave one takes select from b4.
// - Pad a3 trace clock when enabled and free.
`timescale 1ns/1ns

module tsm_pin_mux (
  input  wire logic                          clk_i,              // System clock, 50 MHz.
  input  wire logic                          rst_n_i,            // Synchronous reset, active low.
  // Configuration values.
  input  wire logic [tsm_pkg::REMAP_W-1:0]    remap_option_i,     // Timer remap option.
  input  wire logic [tsm_pkg::PORT_CFG_W-1:0] port_a_low_cfg_i,   // Port A low config.
  input  wire logic [tsm_pkg::PORT_CFG_W-1:0] port_b_high_cfg_i,  // Port B high config.
  input  wire tsm_pkg::tsm_mode_t             one_mode_i,         // Controller one mode.
  input  wire logic [tsm_pkg::CFG_W-1:0]      one_uart_cfg_i,     // Controller one UART config.
  input  wire logic [tsm_pkg::CFG_W-1:0]      one_spi_cfg_i,      // Controller one SPI config.
  input  wire tsm_pkg::tsm_mode_t             two_mode_i,         // Controller two mode.
  input  wire logic [tsm_pkg::CFG_W-1:0]      two_spi_cfg_i,      // Controller two SPI config.
  input  wire logic                          trace_en_i,         // Core trace enabled.
  // Peripheral side.
  input  wire tsm_pkg::tsm_timer_t            timer_i,            // Timer outputs and enables.
  output logic [tsm_pkg::NUM_CH-1:0]          timer_in_o,         // Timer capture inputs.
  input  wire logic                          one_rts_out_i,      // Request-to-send level.
  output logic                               one_slave_select_o, // Slave select to ctrl one.
  input  wire logic                          two_mosi_i,         // Controller two data out.
  output logic                               two_mosi_o,         // Slave data in to ctrl two.
  input  wire logic                          two_miso_i,         // Controller two slave out.
  output logic                               two_miso_o,         // Master data in to ctrl two.
  input  wire logic                          two_spi_clock_i,    // Master SPI clock out.
  output logic                               two_spi_clock_o,    // Slave SPI clock in.
  output logic                               two_slave_select_o, // Slave select in.
  input  wire logic                          two_tw_data_i,      // Two-wire data, 0 pulls low.
  output logic                               two_tw_data_o,      // Two-wire data from pad.
  input  wire logic                          two_tw_clock_i,     // Two-wire clock, 0 pulls low.
  output logic                               two_tw_clock_o,     // Two-wire clock from pad.
  input  wire logic                          cpu_trace_clock_i,  // Trace clock from core.
  // General purpose I/O side.
  input  wire logic [tsm_pkg::NUM_PADS-1:0]   gpio_out_i,         // Plain output levels.
  input  wire logic [tsm_pkg::NUM_PADS-1:0]   gpio_oe_i,          // Plain output enables.
  output logic [tsm_pkg::NUM_PADS-1:0]        gpio_in_o,          // Pad levels read back.
  // Pads: a0, a1, a2, a3, b4 at indices 0 to 4.
  input  wire logic [tsm_pkg::NUM_PADS-1:0]   pad_i,              // Pad input levels.
  output logic [tsm_pkg::NUM_PADS-1:0]        pad_o,              // Pad output levels.
  output logic [tsm_pkg::NUM_PADS-1:0]        pad_oe_o            // Pad output enables.
);

  // ==========================================================================
  // Decode helpers.

  // Extracts one 4-bit pad field from a configuration half.
  function automatic logic [3:0] pad_field(input logic [15:0] cfg, input int unsigned lo);
    pad_field = cfg[lo +: 4];
  endfunction : pad_field

  // True when a field selects an alternate output, push-pull or open drain.
  function automatic logic is_alt(input logic [3:0] f);
    is_alt = (f == tsm_pkg::PAD_CFG_ALT_OUT) || (f == tsm_pkg::PAD_CFG_ALT_OUT_OD);
  endfunction : is_alt

  // ==========================================================================
  // Configuration decode.
  logic [3:0] fld [tsm_pkg::NUM_PADS];  // Per-pad 4-bit fields.
  logic       alt [tsm_pkg::NUM_PADS];  // Per-pad alternate output selected.

  // Each pad reads its own field; port_b_4 sits in the port B high half.
  always_comb begin
    fld[tsm_pkg::PAD_A0] = pad_field(port_a_low_cfg_i, tsm_pkg::PA0_FIELD_LO);
    fld[tsm_pkg::PAD_A1] = pad_field(port_a_low_cfg_i, tsm_pkg::PA1_FIELD_LO);
    fld[tsm_pkg::PAD_A2] = pad_field(port_a_low_cfg_i, tsm_pkg::PA2_FIELD_LO);
    fld[tsm_pkg::PAD_A3] = pad_field(port_a_low_cfg_i, tsm_pkg::PA3_FIELD_LO);
    fld[tsm_pkg::PAD_B4] = pad_field(port_b_high_cfg_i, tsm_pkg::PB4_FIELD_LO);
  end

  // Alternate-output decode repeats per pad.
  for (genvar p = 0; p < tsm_pkg::NUM_PADS; p++) begin : g_alt
    assign alt[p] = is_alt(fld[p]);
  end

  // Remap bits, one per channel.
  logic rm1;  // Channel one moved off port_a_0.
  logic rm2;  // Channel two moved off port_a_3.
  logic rm3;  // Channel three moved off port_a_1.
  logic rm4;  // Channel four on port_b_4 rather than port_a_2.
  assign rm1 = remap_option_i[tsm_pkg::REMAP_CH_ONE_BIT];
  assign rm2 = remap_option_i[tsm_pkg::REMAP_CH_TWO_BIT];
  assign rm3 = remap_option_i[tsm_pkg::REMAP_CH_THREE_BIT];
  assign rm4 = remap_option_i[tsm_pkg::REMAP_CH_FOUR_BIT];

  // Controller role decode.
  logic two_spi;     // Controller two in SPI mode.
  logic two_master;  // Controller two is SPI master.
  logic two_slave;   // Controller two is SPI slave.
  logic two_tw;      // Controller two in two-wire mode.
  logic one_slave;   // Controller one is SPI slave.
  logic rts_act;     // Request-to-send function is live.
  assign two_spi    = (two_mode_i == tsm_pkg::TSM_MODE_SPI);
  assign two_master = two_spi && two_spi_cfg_i[tsm_pkg::SPI_MASTER_BIT];
  assign two_slave  = two_spi && !two_spi_cfg_i[tsm_pkg::SPI_MASTER_BIT];
  assign two_tw     = (two_mode_i == tsm_pkg::TSM_MODE_TWO);
  assign one_slave  = (one_mode_i == tsm_pkg::TSM_MODE_SPI)
                      && !one_spi_cfg_i[tsm_pkg::SPI_MASTER_BIT];
  assign rts_act    = (one_mode_i == tsm_pkg::TSM_MODE_UART)
                      && one_uart_cfg_i[tsm_pkg::UART_FLOW_BIT];

  // Timer channel drive requests on the pad each channel currently owns.
  logic t1_a0;  // Channel one drives port_a_0.
  logic t2_a3;  // Channel two drives port_a_3.
  logic t3_a1;  // Channel three drives port_a_1.
  logic t4_a2;  // Channel four drives port_a_2.
  logic t4_b4;  // Channel four drives port_b_4.
  assign t1_a0 = !rm1 && timer_i.out_en[0] && alt[tsm_pkg::PAD_A0];
  assign t2_a3 = !rm2 && timer_i.out_en[1] && alt[tsm_pkg::PAD_A3];
  assign t3_a1 = !rm3 && timer_i.out_en[2] && alt[tsm_pkg::PAD_A1];
  assign t4_a2 = !rm4 && timer_i.out_en[3] && alt[tsm_pkg::PAD_A2];
  assign t4_b4 =  rm4 && timer_i.out_en[3] && alt[tsm_pkg::PAD_B4];

  // ==========================================================================
  // Pad drive selection.
  tsm_pkg::tsm_pad_drv_t drv_d [tsm_pkg::NUM_PADS];  // Next drive per pad.

  // The timer has first claim on a shared pad; software must release it before a
  // serial function can appear, so a misconfiguration shows the timer, not a clash.
  always_comb begin
    for (int p = 0; p < tsm_pkg::NUM_PADS; p++) begin
      drv_d[p].out = gpio_out_i[p];
      drv_d[p].oe  = gpio_oe_i[p];
    end
    // Port A0: channel one, else SPI master data out.
    if (t1_a0) begin
      drv_d[tsm_pkg::PAD_A0] = '{out: timer_i.out[0], oe: 1'b1};
    end else if (two_master && alt[tsm_pkg::PAD_A0]) begin
      drv_d[tsm_pkg::PAD_A0] = '{out: two_mosi_i, oe: 1'b1};
    end else if (two_slave || (two_tw && alt[tsm_pkg::PAD_A0])) begin
      drv_d[tsm_pkg::PAD_A0] = '{out: 1'b0, oe: 1'b0};
    end
    // Port A1: channel three, else two-wire data or slave data out.
    if (t3_a1) begin
      drv_d[tsm_pkg::PAD_A1] = '{out: timer_i.out[2], oe: 1'b1};
    end else if (two_tw && fld[tsm_pkg::PAD_A1] == tsm_pkg::PAD_CFG_ALT_OUT_OD) begin
      drv_d[tsm_pkg::PAD_A1] = '{out: 1'b0, oe: !two_tw_data_i};
    end else if (two_slave && alt[tsm_pkg::PAD_A1]) begin
      drv_d[tsm_pkg::PAD_A1] = '{out: two_miso_i, oe: 1'b1};
    end else if (two_master) begin
      drv_d[tsm_pkg::PAD_A1] = '{out: 1'b0, oe: 1'b0};
    end
    // Port A2: channel four, else two-wire clock or SPI master clock.
    if (t4_a2) begin
      drv_d[tsm_pkg::PAD_A2] = '{out: timer_i.out[3], oe: 1'b1};
    end else if (two_tw && fld[tsm_pkg::PAD_A2] == tsm_pkg::PAD_CFG_ALT_OUT_OD) begin
      drv_d[tsm_pkg::PAD_A2] = '{out: 1'b0, oe: !two_tw_clock_i};
    end else if (two_master && alt[tsm_pkg::PAD_A2]) begin
      drv_d[tsm_pkg::PAD_A2] = '{out: two_spi_clock_i, oe: 1'b1};
    end else if (two_slave) begin
      drv_d[tsm_pkg::PAD_A2] = '{out: 1'b0, oe: 1'b0};
    end
    // Port A3: channel two, else trace clock, else slave select input.
    if (t2_a3) begin
      drv_d[tsm_pkg::PAD_A3] = '{out: timer_i.out[1], oe: 1'b1};
    end else if (trace_en_i && alt[tsm_pkg::PAD_A3]) begin
      drv_d[tsm_pkg::PAD_A3] = '{out: cpu_trace_clock_i, oe: 1'b1};
    end else if (two_slave) begin
      drv_d[tsm_pkg::PAD_A3] = '{out: 1'b0, oe: 1'b0};
    end
    // Port B4: channel four, else request-to-send, else slave select input.
    if (t4_b4) begin
      drv_d[tsm_pkg::PAD_B4] = '{out: timer_i.out[3], oe: 1'b1};
    end else if (rts_act && alt[tsm_pkg::PAD_B4]) begin
      drv_d[tsm_pkg::PAD_B4] = '{out: one_rts_out_i, oe: 1'b1};
    end else if (one_slave) begin
      drv_d[tsm_pkg::PAD_B4] = '{out: 1'b0, oe: 1'b0};
    end
  end

  // ==========================================================================
  // Registered pad outputs.

  // Pads are registered so every output comes from a flip-flop; reset releases all.
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < tsm_pkg::NUM_PADS; p++) begin
      if (!rst_n_i) begin
        pad_o[p]    <= 1'b0;
        pad_oe_o[p] <= 1'b0;
      end else begin
        pad_o[p]    <= drv_d[p].out;
        pad_oe_o[p] <= drv_d[p].oe;
      end
    end
  end

  // ==========================================================================
  // Registered inputs to peripherals.

  // Timer inputs follow the remap bit only; the output enable plays no part.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      timer_in_o <= 4'h0;
    end else begin
      timer_in_o[0] <= pad_i[tsm_pkg::PAD_A0];
      timer_in_o[1] <= pad_i[tsm_pkg::PAD_A3];
      timer_in_o[2] <= pad_i[tsm_pkg::PAD_A1];
      timer_in_o[3] <= rm4 ? pad_i[tsm_pkg::PAD_B4] : pad_i[tsm_pkg::PAD_A2];
      // The alternate pads of channels one to three lie outside this mux, so a
      // remapped channel reads zero here.
      if (rm1) begin
        timer_in_o[0] <= 1'b0;
      end
      if (rm2) begin
        timer_in_o[1] <= 1'b0;
      end
      if (rm3) begin
        timer_in_o[2] <= 1'b0;
      end
    end
  end

  // Serial controller inputs; idle levels are driven when the role is off.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      two_mosi_o         <= 1'b0;
      two_miso_o         <= 1'b0;
      two_spi_clock_o    <= 1'b0;
      two_slave_select_o <= 1'b1;
      one_slave_select_o <= 1'b1;
      two_tw_data_o      <= 1'b1;
      two_tw_clock_o     <= 1'b1;
    end else begin
      two_mosi_o         <= two_slave ? pad_i[tsm_pkg::PAD_A0] : 1'b0;
      two_miso_o         <= two_master ? pad_i[tsm_pkg::PAD_A1] : 1'b0;
      two_spi_clock_o    <= two_slave ? pad_i[tsm_pkg::PAD_A2] : 1'b0;
      two_slave_select_o <= two_slave ? pad_i[tsm_pkg::PAD_A3] : 1'b1;
      one_slave_select_o <= one_slave ? pad_i[tsm_pkg::PAD_B4] : 1'b1;
      two_tw_data_o      <= two_tw ? pad_i[tsm_pkg::PAD_A1] : 1'b1;
      two_tw_clock_o     <= two_tw ? pad_i[tsm_pkg::PAD_A2] : 1'b1;
    end
  end

  // Plain input readback is always live, whatever function owns the pad.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gpio_in_o <= 5'h00;
    end else begin
      gpio_in_o <= pad_i;
    end
  end

endmodule : tsm_pin_mux

// *** tsm_pad_model.sv ***
// Behavioural model of the board side of the five muxed pads.
`timescale 1ns/1ns

module tsm_pad_model (
  input  wire logic [4:0] dev_out_i,  // Levels the mux drives.
  input  wire logic [4:0] dev_oe_i,   // High while the mux drives a pad.
  input  wire logic [4:0] ext_oe_i,   // High while the board drives a pad.
  input  wire logic [4:0] ext_val_i,  // Levels the board drives.
  output logic      [4:0] level_o     // Resolved pad levels.
);
  // ==========================================================================
  // Pad resolution.
  // Every pad has a board pull-up, so a released line reads high, as an
  // open-drain two-wire bus needs. The device wins over a board driver; a
  // handover where both drive lasts until the registered device enable drops.
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      if (dev_oe_i[k]) begin
        level_o[k] = dev_out_i[k];
      end else if (ext_oe_i[k]) begin
        level_o[k] = ext_val_i[k];
      end else begin
        level_o[k] = 1'b1;
      end
    end
  end
endmodule : tsm_pad_model

// *** tsm_pin_mux_chk.sv ***
// Concurrent checks on the ports of the timer and serial pin mux.
`timescale 1ns/1ns

module tsm_pin_mux_chk (
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic [7:0]          remap_option_i,
  input wire logic [15:0]         port_a_low_cfg_i,
  input wire logic [15:0]         port_b_high_cfg_i,
  input wire tsm_pkg::tsm_mode_t  one_mode_i,
  input wire logic [7:0]          one_uart_cfg_i,
  input wire logic [7:0]          one_spi_cfg_i,
  input wire tsm_pkg::tsm_mode_t  two_mode_i,
  input wire logic [7:0]          two_spi_cfg_i,
  input wire logic                trace_en_i,
  input wire tsm_pkg::tsm_timer_t timer_i,
  input wire logic [3:0]          timer_in_o,
  input wire logic                one_slave_select_o,
  input wire logic                two_mosi_i,
  input wire logic                two_mosi_o,
  input wire logic                two_spi_clock_i,
  input wire logic                two_spi_clock_o,
  input wire logic                two_slave_select_o,
  input wire logic                two_tw_data_i,
  input wire logic                cpu_trace_clock_i,
  input wire logic [4:0]          gpio_oe_i,
  input wire logic [4:0]          pad_i,
  input wire logic [4:0]          pad_o,
  input wire logic [4:0]          pad_oe_o
);
  // ==========================================================================
  // Helpers.
  logic [3:0] home;                // Channel enabled and left on its home pad.
  logic [3:0] fa0, fa1, fa2, fa3;  // Port A pad fields.
  assign home = timer_i.out_en & ~remap_option_i[7:4];
  assign {fa3, fa2, fa1, fa0} = port_a_low_cfg_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================================
  // Assertions; all outputs follow the inputs of the previous edge.
  chk_ch_one_home: assert property (home[0] && fa0 == 4'h9 |=>
    pad_oe_o[0] && pad_o[0] == $past(timer_i.out[0])) else $error("ch1 not on a0");
  chk_ch_two_home: assert property (home[1] && fa3 == 4'h9 |=>
    pad_oe_o[3] && pad_o[3] == $past(timer_i.out[1])) else $error("ch2 not on a3");
  chk_ch_three_home: assert property (home[2] && fa1 == 4'h9 |=>
    pad_oe_o[1] && pad_o[1] == $past(timer_i.out[2])) else $error("ch3 not on a1");
  chk_ch_four_low: assert property (home[3] && fa2 == 4'h9 |=>
    pad_oe_o[2] && pad_o[2] == $past(timer_i.out[3])) else $error("ch4 not on a2");
  chk_ch_four_high: assert property (timer_i.out_en[3] && remap_option_i[7]
    && port_b_high_cfg_i[3:0] == 4'h9 |=> pad_oe_o[4] && pad_o[4] == $past(timer_i.out[3]))
    else $error("ch4 not on b4");
  chk_ch_four_input: assert property (1'b1 |=>
    timer_in_o[3] == $past(remap_option_i[7] ? pad_i[4] : pad_i[2])) else $error("ch4 input");
  chk_rts_flow_gate: assert property (!(timer_i.out_en[3] && remap_option_i[7])
    && port_b_high_cfg_i[3:0] == 4'h9 && one_mode_i == tsm_pkg::TSM_MODE_UART && !gpio_oe_i[4]
    |=> pad_oe_o[4] == $past(one_uart_cfg_i[5])) else $error("rts gate");
  chk_spi_master_out: assert property (two_mode_i == tsm_pkg::TSM_MODE_SPI
    && two_spi_cfg_i[4] && !home[0] && !home[3] && fa0 == 4'h9 && fa2 == 4'h9
    |=> pad_o[0] == $past(two_mosi_i) && pad_o[2] == $past(two_spi_clock_i)
    && pad_oe_o[0] && pad_oe_o[2]) else $error("spi master out");
  chk_spi_slave_in: assert property (two_mode_i == tsm_pkg::TSM_MODE_SPI
    && !two_spi_cfg_i[4] |=> {two_mosi_o, two_spi_clock_o, two_slave_select_o}
    == {$past(pad_i[0]), $past(pad_i[2]), $past(pad_i[3])}) else $error("spi slave in");
  chk_tw_data_drive: assert property (two_mode_i == tsm_pkg::TSM_MODE_TWO
    && !home[2] && fa1 == 4'hD |=> pad_oe_o[1] == !$past(two_tw_data_i))
    else $error("two-wire data drive");
  chk_trace_out: assert property (trace_en_i && fa3 == 4'h9 && !home[1] |=>
    pad_oe_o[3] && pad_o[3] == $past(cpu_trace_clock_i)) else $error("trace clock");
  chk_one_select_in: assert property (one_mode_i == tsm_pkg::TSM_MODE_SPI
    && !one_spi_cfg_i[4] |=> one_slave_select_o == $past(pad_i[4])) else $error("select one");
  chk_gpio_plain: assert property (port_a_low_cfg_i == 16'h4444
    && port_b_high_cfg_i[3:0] == 4'h4 |=> pad_oe_o == $past(gpio_oe_i)) else $error("gpio oe");
endmodule : tsm_pin_mux_chk

bind tsm_pin_mux tsm_pin_mux_chk tsm_pin_mux_chk_i (.*);

// *** tb_top.sv ***
// Self-checking bench for the timer and serial pin mux.
`timescale 1ns/1ns
`define CMP(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end

module tb_top;
  // ==========================================================================
  // Signals; names match the mux ports so the instance connects by name.
  logic                clk_i, rst_n_i, trace_en_i, one_rts_out_i, two_mosi_i, two_miso_i;
  logic                two_spi_clock_i, two_tw_data_i, two_tw_clock_i, cpu_trace_clock_i;
  logic [7:0]          remap_option_i, one_uart_cfg_i, one_spi_cfg_i, two_spi_cfg_i, tm;
  logic [15:0]         port_a_low_cfg_i, port_b_high_cfg_i, fld;
  tsm_pkg::tsm_mode_t  one_mode_i, two_mode_i;
  tsm_pkg::tsm_timer_t timer_i;
  logic [4:0]          gpio_out_i, gpio_oe_i, gpio_in_o, pad_i, pad_o, pad_oe_o;
  logic [4:0]          ext_oe, ext_val;  // Board drive of the pads.
  logic [3:0]          timer_in_o;
  logic                one_slave_select_o, two_mosi_o, two_miso_o, two_spi_clock_o;
  logic                two_slave_select_o, two_tw_data_o, two_tw_clock_o;
  int                  num_errors = 0;
  int                  comparisons = 0;
  int                  pidx [3] = '{0, 3, 1};   // Home pads of channels 1 to 3.
  int                  lo [3] = '{0, 12, 4};    // Low bit of those pads' fields.

  tsm_pin_mux tsm_pin_mux_i (.*);
  tsm_pad_model tsm_pad_model_i (.dev_out_i(pad_o), .dev_oe_i(pad_oe_o), .ext_oe_i(ext_oe),
                                 .ext_val_i(ext_val), .level_o(pad_i));

  // 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Tasks. Inputs change at the falling edge; one edge later outputs are due.
  task automatic tick();
    @(negedge clk_i);
  endtask : tick

  // Sets pad fields, remap and timer, and puts every other input at idle.
  task automatic setp(input logic [15:0] a, input logic [3:0] b, input logic [7:0] rm,
                      input logic [7:0] t);
    port_a_low_cfg_i = a;
    port_b_high_cfg_i = {12'h444, b};
    remap_option_i = rm;
    timer_i = t;
    one_mode_i = tsm_pkg::TSM_MODE_OFF;
    two_mode_i = tsm_pkg::TSM_MODE_OFF;
    {one_uart_cfg_i, one_spi_cfg_i, two_spi_cfg_i} = 24'h000000;
    {trace_en_i, one_rts_out_i, two_mosi_i, two_miso_i, two_spi_clock_i} = 5'h00;
    {two_tw_data_i, two_tw_clock_i, cpu_trace_clock_i} = 3'h6;
    {gpio_out_i, gpio_oe_i, ext_oe, ext_val} = 20'h00000;
  endtask : setp

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (2000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    setp(16'h4444, 4'h4, 8'h00, 8'h00);
    rst_n_i = 1'b0;
    repeat (10) tick();
    `CMP("reset oe", 5'h00, pad_oe_o)
    `CMP("reset select", 1'b1, one_slave_select_o)
    rst_n_i = 1'b1;
    done("reset");
    // Channel four moves between a2 and b4; its input follows the remap bit.
    for (int r = 0; r < 2; r++) begin
      setp(16'h4944, 4'h9, {r[0], 7'h00}, 8'h88);
      tick();
      `CMP("ch4 a2 oe", r == 0, pad_oe_o[2])
      `CMP("ch4 b4 oe", r == 1, pad_oe_o[4])
      timer_i.out_en[3] = 1'b0;
      ext_oe = 5'h14;
      ext_val = 5'h10;
      repeat (2) tick();
      `CMP("ch4 input", r == 1, timer_in_o[3])
    end
    done("channel four");
    // Channels one to three: home pad, enable gate, field position, remap.
    for (int c = 0; c < 3; c++) begin
      fld = (16'h4444 & ~(16'hF << lo[c])) | (16'h9 << lo[c]);
      tm = {4'(1 << c), 4'(1 << c)};
      setp(fld, 4'h4, 8'h00, tm);
      tick();
      `CMP("ch home oe", 1'b1, pad_oe_o[pidx[c]])
      `CMP("ch home out", 1'b1, pad_o[pidx[c]])
      timer_i.out_en = 4'h0;
      tick();
      `CMP("ch disabled", 1'b0, pad_oe_o[pidx[c]])
      `CMP("ch input home", 1'b1, timer_in_o[c])
      setp(fld ^ 16'hDDDD, 4'h4, 8'h00, tm);
      tick();
      `CMP("ch other field", 1'b0, pad_oe_o[pidx[c]])
      setp(fld, 4'h4, 8'(1 << (4 + c)), tm);
      tick();
      `CMP("ch remapped", 1'b0, pad_oe_o[pidx[c]])
    end
    done("channels one to three");
    // Request-to-send on b4 with channel four left home; then slave select.
    setp(16'h4444, 4'h9, 8'h00, 8'h08);
    one_mode_i = tsm_pkg::TSM_MODE_UART;
    one_uart_cfg_i = 8'h20;
    one_rts_out_i = 1'b1;
    tick();
    `CMP("rts drive", 2'b11, {pad_oe_o[4], pad_o[4]})
    one_uart_cfg_i = 8'h00;
    tick();
    `CMP("rts no flow", 1'b0, pad_oe_o[4])
    one_mode_i = tsm_pkg::TSM_MODE_SPI;
    one_uart_cfg_i = 8'h20;
    ext_oe = 5'h10;
    tick();
    `CMP("rts not uart", 1'b0, pad_oe_o[4])
    `CMP("select one", 1'b0, one_slave_select_o)
    done("controller one");
    // Controller two SPI master, channel one moved away, then SPI slave.
    setp(16'h4949, 4'h4, 8'h10, 8'h01);
    two_mode_i = tsm_pkg::TSM_MODE_SPI;
    two_spi_cfg_i = 8'h10;
    {two_mosi_i, two_spi_clock_i} = 2'b11;
    ext_oe = 5'h02;
    ext_val = 5'h02;
    tick();
    `CMP("master oe", 3'b101, pad_oe_o[2:0])
    `CMP("master out", 2'b11, {pad_o[2], pad_o[0]})
    `CMP("master in", 1'b1, two_miso_o)
    port_a_low_cfg_i = 16'h4494;
    two_spi_cfg_i = 8'h00;
    two_miso_i = 1'b1;
    ext_oe = 5'h0D;
    ext_val = 5'h05;
    tick();
    `CMP("slave in", 3'b110, {two_mosi_o, two_spi_clock_o, two_slave_select_o})
    `CMP("slave out", 2'b11, {pad_oe_o[1], pad_o[1]})
    done("controller two spi");
    // Two-wire lines pull low only; a released line reads the pull-up.
    setp(16'h4DD4, 4'h4, 8'hC0, 8'h0C);
    two_mode_i = tsm_pkg::TSM_MODE_TWO;
    two_tw_data_i = 1'b0;
    tick();
    `CMP("tw data low", 2'b10, {pad_oe_o[1], pad_o[1]})
    {two_tw_data_i, two_tw_clock_i} = 2'b10;
    tick();
    `CMP("tw clock low", 2'b10, pad_oe_o[2:1])
    tick();
    `CMP("tw read", 2'h2, {two_tw_data_o, two_tw_clock_o})
    done("two-wire");
    // Trace clock on a3 unless channel two owns the pad.
    setp(16'h9444, 4'h4, 8'h00, 8'h00);
    trace_en_i = 1'b1;
    cpu_trace_clock_i = 1'b1;
    tick();
    `CMP("trace on", 2'b11, {pad_oe_o[3], pad_o[3]})
    timer_i = 8'h02;
    tick();
    `CMP("trace blocked", 1'b0, pad_o[3])
    remap_option_i = 8'h20;
    tick();
    `CMP("trace remap", 1'b1, pad_o[3])
    done("trace");
    // Plain digital I/O when no alternate function is chosen.
    setp(16'h4444, 4'h4, 8'h00, 8'h00);
    gpio_oe_i = 5'h15;
    gpio_out_i = 5'h1F;
    ext_oe = 5'h0A;
    tick();
    `CMP("gpio oe", 5'h15, pad_oe_o)
    tick();
    `CMP("gpio in", 5'h15, gpio_in_o)
    done("gpio");
    end_sim();
  end
endmodule : tb_top
